// [hdl/mcs_sequencer.sv]
// Four-state control sequencer for a micro-programmed processor.
// Assumes micro-instruction fields, module decodes and handshake inputs
// arrive from logic on core_clk, and an APB master on the same clock.
//
// Overview of operation
// - two state flops decode to four one-hot states
// - state zero decodes and gates the buses
// - memory control issued when leaving state zero
// - indirect reference goes to state two, else one
// - state two read replaces B bus, then one
// - store write skips modules, goes to three
// - start in state one, wait for finished
// - untaken conditional transfer goes one to three
// - otherwise state one returns to zero
// - load micro-instruction leaving state one
// - state three fetches next, loads micro-instruction
// - clear or address jam forces state three
// - D flops, no set term means clear
// - zero, indirect, not module zero sets b
// - zero, module zero or direct sets a
// - leaving state two always sets a
// - store write in state two sets b
// - taken condition, not inhibited, sets both
// - interrupt or trap suppresses the start
`timescale 1ns/1ns
`default_nettype none

module mcs_sequencer (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [mcs_pkg::UI_W-1:0]  storeData,
  input  wire logic                      moduleZeroSelect_n,
  input  wire logic                      conditionalRegTransfer,
  input  wire logic                      conditionSignal,
  input  wire logic                      transferInhibit_n,
  input  wire logic                      interruptRequest,
  input  wire logic                      trapRequest,
  input  wire logic                      systemClear_n,
  input  wire logic                      addressJam,
  input  wire logic                      moduleFinished,
  output logic                           stateA_r,
  output logic                           stateB_r,
  output logic                           stateZeroDecode_r,
  output logic                           stateOneModuleComm_r,
  output logic                           stateTwoStoreRef_r,
  output logic                           stateThreeNextFetch_r,
  output logic                           moduleStart_r,
  output logic [mcs_pkg::UI_W-1:0]       microInstructionRegister_r,
  output logic                           uinstLoad_r,
  output logic                           memCtlIssue_r,
  output logic                           storeRead_r,
  output logic                           storeWrite_r
);
  import mcs_pkg::*;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  mcs_state_t state;
  mcs_state_t state_nxt;
  logic       aNxt;
  logic       bNxt;
  logic       sZero;
  logic       sOne;
  logic       sTwo;
  logic       sThree;
  logic       indirectBit;
  logic       storeReference;
  logic       storeWriteDec;
  logic       conditionalBit;
  logic       xferToThree;
  logic       holdOne;
  logic       forced;
  logic       jamSw_r;
  logic       startNxt;
  logic       apbDone;
  logic [31:0] rdData;
  logic       addrOk;

  // Current state and its raw decode.
  assign state  = mcs_state_t'({stateB_r, stateA_r});
  assign sZero  = (state == MCS_S0);
  assign sOne   = (state == MCS_S1);
  assign sTwo   = (state == MCS_S2);
  assign sThree = (state == MCS_S3);

  // Micro-instruction fields steering the transitions.
  assign indirectBit    = microInstructionRegister_r[IND_POS];
  assign conditionalBit = microInstructionRegister_r[COND_POS];
  assign storeWriteDec  = microInstructionRegister_r[WR3_POS]
                        & microInstructionRegister_r[WR2_POS];
  assign storeReference = indirectBit & moduleZeroSelect_n;

  // Untaken conditional transfer that needs a sequential fetch.
  assign xferToThree = conditionalRegTransfer & conditionalBit
                     & conditionSignal & transferInhibit_n;

  // The sequencer halts in state one while start is high and the module has not answered.
  // A clear or jam still overrides the hold, so a silent module cannot lock it up.
  assign holdOne = sOne & moduleStart_r & ~moduleFinished;

  // Clear from the system or an address jam from pin or software.
  // The software jam acts one cycle after its bus write completes.
  assign forced = ~systemClear_n | addressJam | jamSw_r;

  // Set terms of the two D flops; no active term means clear.
  always_comb begin
    aNxt = (sZero & ~storeReference)
         | sTwo
         | (sOne & xferToThree);
    bNxt = (sZero & storeReference)
         | (sTwo & storeWriteDec)
         | (sOne & xferToThree);
    if (forced) begin
      state_nxt = MCS_S3;
    end else if (holdOne) begin
      state_nxt = state;
    end else begin
      state_nxt = mcs_state_t'({bNxt, aNxt});
    end
  end

  // Start is raised in state one unless module zero is selected or an interrupt or trap is pending.
  assign startNxt = (state_nxt == MCS_S1) & moduleZeroSelect_n
                  & ~interruptRequest & ~trapRequest;

  // State flops, recomputed on every clock.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateA_r <= ST_RST[0];
      stateB_r <= ST_RST[1];
    end else begin
      stateA_r <= state_nxt[0];
      stateB_r <= state_nxt[1];
    end
  end

  // Registered one-hot state decode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateZeroDecode_r     <= (ST_RST == MCS_S0);
      stateOneModuleComm_r  <= (ST_RST == MCS_S1);
      stateTwoStoreRef_r    <= (ST_RST == MCS_S2);
      stateThreeNextFetch_r <= (ST_RST == MCS_S3);
    end else begin
      stateZeroDecode_r     <= (state_nxt == MCS_S0);
      stateOneModuleComm_r  <= (state_nxt == MCS_S1);
      stateTwoStoreRef_r    <= (state_nxt == MCS_S2);
      stateThreeNextFetch_r <= (state_nxt == MCS_S3);
    end
  end

  // Module start handshake toward the other modules.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      moduleStart_r <= 1'b0;
    end else begin
      moduleStart_r <= startNxt;
    end
  end

  // Micro-instruction register loads leaving state one or three.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      microInstructionRegister_r <= UI_RST;
      uinstLoad_r                <= 1'b0;
    end else begin
      uinstLoad_r <= 1'b0;
      if (!forced && ((sOne && !holdOne) || sThree)) begin
        microInstructionRegister_r <= storeData;
        uinstLoad_r                <= 1'b1;
      end
    end
  end

  // Transition strobes for memory control and control-store access.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      memCtlIssue_r <= 1'b0;
      storeRead_r   <= 1'b0;
      storeWrite_r  <= 1'b0;
    end else begin
      memCtlIssue_r <= sZero & ~forced;
      storeRead_r   <= sTwo & ~storeWriteDec & ~forced;
      storeWrite_r  <= sTwo & storeWriteDec & ~forced;
    end
  end

  // APB access phase: answer on the second cycle of penable.
  assign apbDone = psel & penable & pready;
  assign addrOk  = (paddr == CTRL_OFS) | (paddr == STAT_OFS);

  // Read mux; the control register reads back as zero.
  always_comb begin
    rdData = 32'h0000_0000;
    if (paddr == STAT_OFS) begin
      rdData[STA_A_POS]    = stateA_r;
      rdData[STA_B_POS]    = stateB_r;
      rdData[STA_MODULE_START_POS] = moduleStart_r;
      rdData[STA_HOLD_POS] = holdOne;
    end
  end

  // Bus answer flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdData : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~addrOk;
    end
  end

  // Software address jam; a one-cycle pulse per write of one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      jamSw_r <= 1'b0;
    end else begin
      jamSw_r <= apbDone & pwrite & (paddr == CTRL_OFS) & pwdata[JAM_POS];
    end
  end

  // Checks on the state decode and transitions.
  a_onehot_decode: assert property (
    $onehot({stateZeroDecode_r, stateOneModuleComm_r,
             stateTwoStoreRef_r, stateThreeNextFetch_r})
    && stateThreeNextFetch_r == (stateA_r && stateB_r)
    && stateOneModuleComm_r == (stateA_r && !stateB_r))
    else $error("State decode does not match flops.");

  a_decode_rest: assert property (
    (stateZeroDecode_r == (!stateA_r && !stateB_r))
    && (stateTwoStoreRef_r == (stateB_r && !stateA_r)))
    else $error("State zero or two decode does not match flops.");

  a_clear_forces: assert property (
    (!systemClear_n || addressJam) |=> (stateA_r && stateB_r))
    else $error("Clear or jam did not force state three.");

  a_sw_jam: assert property (
    jamSw_r |=> (stateA_r && stateB_r && !uinstLoad_r))
    else $error("Software jam did not force state three.");

  a_forced_quiet: assert property (
    forced |=> (!uinstLoad_r && !memCtlIssue_r && !storeRead_r
                && !storeWrite_r && !moduleStart_r))
    else $error("Load or strobe seen while forced.");

  a_zero_exit: assert property (
    (sZero && !forced) |=> (stateA_r != stateB_r))
    else $error("State zero did not go to state one or two.");

  a_zero_to_two: assert property (
    (sZero && storeReference && !forced) |=> (!stateA_r && stateB_r))
    else $error("Indirect reference missed state two.");

  a_zero_to_one: assert property (
    (sZero && !storeReference && !forced) |=> (stateA_r && !stateB_r))
    else $error("Direct case missed state one.");

  a_two_exit: assert property (
    (sTwo && !forced) |=> (stateA_r && (stateB_r == $past(storeWriteDec))))
    else $error("Wrong exit from state two.");

  a_one_to_three: assert property (
    (sOne && !holdOne && xferToThree && !forced) |=> (stateA_r && stateB_r))
    else $error("Untaken transfer missed state three.");

  a_one_to_zero: assert property (
    (sOne && !holdOne && !xferToThree && !forced) |=> (!stateA_r && !stateB_r))
    else $error("State one did not return to zero.");

  a_start_holds: assert property (
    (holdOne && !forced) |=> sOne)
    else $error("Sequencer left state one before finish.");

  a_start_only_one: assert property (
    moduleStart_r |-> stateOneModuleComm_r)
    else $error("Start raised outside state one.");

  a_start_raise: assert property (
    (sTwo && !storeWriteDec && !forced && moduleZeroSelect_n
     && !interruptRequest && !trapRequest) |=> moduleStart_r)
    else $error("Start missing on entry to state one.");

  a_module_zero: assert property (
    !moduleZeroSelect_n |=> !moduleStart_r)
    else $error("Start raised for module zero.");

  a_start_suppress: assert property (
    (interruptRequest || trapRequest) |=> !moduleStart_r)
    else $error("Start raised during interrupt or trap.");

  a_uinst_load: assert property (
    (sOne && !holdOne && !forced) |=>
      (uinstLoad_r && microInstructionRegister_r == $past(storeData)))
    else $error("Micro-instruction not loaded out of state one.");

  a_uinst_steady: assert property (
    (sZero || sTwo) |=> (!uinstLoad_r && $stable(microInstructionRegister_r)))
    else $error("Micro-instruction loaded out of state zero or two.");

  a_three_load: assert property (
    (sThree && !forced) |=> (uinstLoad_r && stateZeroDecode_r && !stateA_r && !stateB_r))
    else $error("State three did not load and move on.");

  a_mem_issue: assert property (
    (sZero && !forced) |=> (memCtlIssue_r && !stateZeroDecode_r))
    else $error("Memory control not issued leaving state zero.");

  a_read_path: assert property (
    (sTwo && !storeWriteDec && !forced) |=> (storeRead_r && sOne))
    else $error("Store read did not lead to state one.");

  a_write_path: assert property (
    (sTwo && storeWriteDec && !forced) |=> (storeWrite_r && !moduleStart_r))
    else $error("Store write started a module.");

  a_apb_answer: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle.");

  // Main scenarios.
  c_module_wait: cover property (holdOne [*3] ##1 (sOne && moduleFinished));
  c_store_write: cover property (sZero ##1 sTwo ##1 sThree ##1 sZero);
  c_store_read: cover property (sTwo ##1 sOne ##1 sZero);
  c_cond_skip: cover property ((sOne && xferToThree) ##1 sThree);
  c_sw_jam: cover property (jamSw_r ##1 sThree);

endmodule

`default_nettype wire

// [inc/mcs_pkg.sv]
// Shared constants and types for the micro-sequencer control state logic.
// Assumes a single core clock domain and an APB register master.
`default_nettype none

package mcs_pkg;

  // Control state code, written as {state_b, state_a}.
  typedef enum logic [1:0] {
    MCS_S0 = 2'b00,
    MCS_S1 = 2'b01,
    MCS_S2 = 2'b10,
    MCS_S3 = 2'b11
  } mcs_state_t;

  // Width of the micro-instruction word.
  localparam int UI_W = 32;

  // Bit positions in the micro-instruction word; bit 00 is the MSB.
  localparam int IND_POS  = 26; // Bit 05, indirect.
  localparam int WR3_POS  = 28; // Bit 03.
  localparam int WR2_POS  = 29; // Bit 02.
  localparam int COND_POS = 6;  // Bit 25, conditional.

  // Reset values.
  localparam mcs_state_t ST_RST = MCS_S3;
  localparam logic [UI_W-1:0] UI_RST = 32'h0000_0000;

  // APB register byte offsets.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // Field positions in the control register.
  localparam int JAM_POS = 0;

  // Field positions in the status register.
  localparam int STA_A_POS    = 0;
  localparam int STA_B_POS    = 1;
  localparam int STA_MODULE_START_POS = 2;
  localparam int STA_HOLD_POS = 3;

endpackage

`default_nettype wire

// [tb/mcs_module_partner.sv]
// Model of the other processor modules on the start/finished handshake.
// Assumes start is a level that stays high until finished has been seen.
`timescale 1ns/1ns
`default_nettype none

module mcs_module_partner (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       moduleStart,
  input  wire logic [3:0] delay,
  output logic            moduleFinished
);
  logic [3:0] waitCnt_r;

  // Wait the chosen number of cycles, then return finished for one cycle.
  always_ff @(posedge core_clk) begin
    if (rst || !moduleStart || moduleFinished) begin
      waitCnt_r      <= 4'h0;
      moduleFinished <= 1'b0;
    end else if (waitCnt_r >= delay) begin
      moduleFinished <= 1'b1;
    end else begin
      waitCnt_r <= waitCnt_r + 4'h1;
    end
  end
endmodule

`default_nettype wire

// [tb/microcode_control_state_sequencer_test.sv]
// Self-checking bench: random micro-words and controls against a cycle model.
// Assumes the sequencer package and the module partner model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module microcode_control_state_sequencer_test;
  import mcs_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, storeData, uinst, rd, uM;
  logic        modZero_n, condXfer, condSig, inhibit_n, intReq, trapReq, clear_n, jamIn, fin;
  logic        stA, stB, d0, d1, d2, d3, start, ld, mem, srd, swr, holdClr, runRand;
  logic        startM, jamM, ldM, memM, srdM, swrM;
  logic [3:0]  dly;
  logic [63:0] seenV, expV;
  mcs_state_t  stM;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  mcs_sequencer mcs_sequencer_inst (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .storeData, .moduleZeroSelect_n(modZero_n), .conditionalRegTransfer(condXfer),
    .conditionSignal(condSig), .transferInhibit_n(inhibit_n), .interruptRequest(intReq), .trapRequest(trapReq),
    .systemClear_n(clear_n), .addressJam(jamIn), .moduleFinished(fin), .stateA_r(stA), .stateB_r(stB),
    .stateZeroDecode_r(d0), .stateOneModuleComm_r(d1), .stateTwoStoreRef_r(d2), .stateThreeNextFetch_r(d3),
    .moduleStart_r(start), .microInstructionRegister_r(uinst), .uinstLoad_r(ld), .memCtlIssue_r(mem),
    .storeRead_r(srd), .storeWrite_r(swr));

  mcs_module_partner mcs_module_partner_inst (.core_clk, .rst, .moduleStart(start), .delay(dly),
    .moduleFinished(fin));

  // Free-running 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Compares one value with its expectation and counts the result.
  task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high, the watchdog bounds the wait.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Next control state from the model's state and the inputs sampled now.
  function automatic mcs_state_t nxt(logic hold);
    if (!clear_n || jamIn || jamM) return MCS_S3;
    case (stM)
      MCS_S0: return (uM[IND_POS] && modZero_n) ? MCS_S2 : MCS_S1;
      MCS_S2: return (uM[WR3_POS] && uM[WR2_POS]) ? MCS_S3 : MCS_S1;
      MCS_S1: return hold ? MCS_S1 : (condXfer && uM[COND_POS] && condSig && inhibit_n) ? MCS_S3 : MCS_S0;
      default: return MCS_S0;
    endcase
  endfunction

  // Reference model, stepped at each rising edge.
  always @(posedge core_clk) begin
    mcs_state_t n;
    logic hold, frc, load;
    cyc++;
    hold = stM == MCS_S1 && startM && !fin;
    frc = !clear_n || jamIn || jamM;
    load = !frc && (stM == MCS_S3 || (stM == MCS_S1 && !hold));
    n = nxt(hold);
    if (rst) begin
      stM <= MCS_S3;
      {startM, jamM, ldM, memM, srdM, swrM} <= 6'h00;
      uM <= 32'h0000_0000;
    end else begin
      stM <= n;
      startM <= n == MCS_S1 && modZero_n && !intReq && !trapReq;
      ldM <= load;
      if (load) uM <= storeData;
      memM <= !frc && stM == MCS_S0;
      srdM <= !frc && stM == MCS_S2 && n == MCS_S1;
      swrM <= !frc && stM == MCS_S2 && n == MCS_S3;
      jamM <= psel && penable && pready && pwrite && paddr == CTRL_OFS && pwdata[JAM_POS];
    end
  end

  // Output word of the design and of the model, compared every cycle.
  assign seenV = {21'h0, stB, stA, d3, d2, d1, d0, start, ld, mem, srd, swr, uinst};
  assign expV = {21'h0, stM, stM == MCS_S3, stM == MCS_S2, stM == MCS_S1, stM == MCS_S0,
                 startM, ldM, memM, srdM, swrM, uM};
  always @(negedge core_clk) if (cyc > 1) check("outputs", seenV, expV);

  // Random micro-words and control inputs; the module select moves only in state three.
  always @(posedge core_clk) if (runRand) begin
    storeData <= $urandom;
    {condXfer, condSig, inhibit_n} <= 3'($urandom);
    intReq <= $urandom_range(15) == 0;
    trapReq <= $urandom_range(15) == 0;
    clear_n <= !holdClr && $urandom_range(40) != 0;
    jamIn <= $urandom_range(40) == 0;
    if (stM == MCS_S3) begin
      modZero_n <= 1'($urandom);
      dly <= 4'($urandom);
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #(50 * 20000);
    fail_count++;
    summarize;
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h4116bda9));
    {rst, clear_n} = 2'b11;
    {psel, penable, pwrite, modZero_n, condXfer, condSig, inhibit_n, intReq, trapReq, jamIn} = 10'h000;
    {holdClr, runRand} = 2'b00;
    paddr = 12'h000;
    {pwdata, storeData} = 64'h0;
    dly = 4'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    runRand <= 1'b1;
    $display("test reset done");
    repeat (2000) @(posedge core_clk);
    $display("test random run done");
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, CTRL_OFS, 32'h0000_0001, rd, err);
      check("jam error", err, 64'h0);
      repeat ($urandom_range(9)) @(posedge core_clk);
    end
    $display("test jam done");
    holdClr <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, STAT_OFS, 32'h0, rd, err);
    check("status", {err, rd}, 64'h3);
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    check("control", {err, rd}, 64'h0);
    apb(1'b1, STAT_OFS, 32'h0000_000f, rd, err);
    check("status write", err, 64'h0);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check("unmapped", {err, rd}, 64'h1_0000_0000);
    holdClr <= 1'b0;
    $display("test register access done");
    repeat (200) @(posedge core_clk);
    summarize;
  end
endmodule

`default_nettype wire
